// [rtl/pts_pkg.sv]
// constants and types for the ping and time synchronization block
package pts_pkg;
   localparam int CLK_MHZ = 125;
   localparam int CLK_PERIOD_NS = 8;
   // ping trigger least low time
   localparam int TRIG_LOW_US = 25;
   localparam int TRIG_LOW_CYC = (TRIG_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // sync output pulse width
   localparam int SYNC_PULSE_US = 100;
   localparam int SYNC_PULSE_CYC = (SYNC_PULSE_US * 1000) / CLK_PERIOD_NS;
   // time counter chain
   localparam int TICK_WRAP = 1000;
   localparam int HALF_SECOND_MS = 500;
   localparam int SUB_W = 10;
   localparam int SEC_W = 32;
   localparam int CNT_W = 16;
   localparam logic [SUB_W-1:0] SUB_RESET = 10'h000;
   localparam logic [SEC_W-1:0] SEC_RESET = 32'h0000_0000;
   typedef enum logic [1:0] {PTS_ARMED, PTS_FIRE, PTS_HOLD} pts_ping_t;
endpackage : pts_pkg

// [rtl/pts_ping_time_sync.sv]
// ping gating, master sync pulse and time-of-day counters
`timescale 1ns/100ps
module pts_ping_time_sync
   import pts_pkg::*;
#(
   parameter int TRIG_CYC = TRIG_LOW_CYC,
   parameter int PULSE_CYC = SYNC_PULSE_CYC
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   // external sync pins
   input wire logic PING_TRIGGER_LINE,
   input wire logic PULSE_PER_SECOND_INPUT,
   // configuration
   input wire logic MASTER_MODE,
   input wire logic HOST_TIME_MODE,
   input wire logic HOST_SET_VALID,
   input wire logic [SEC_W-1:0] HOST_SET_SEC,
   input wire logic [SUB_W-1:0] HOST_SET_MS,
   // transmitter side
   input wire logic TX_READY,
   output logic TX_START,
   output logic SYNC_OUT_N,
   // time of day
   output logic [SUB_W-1:0] TIME_NS,
   output logic [SUB_W-1:0] TIME_US,
   output logic [SUB_W-1:0] TIME_MS,
   output logic [SEC_W-1:0] TIME_SEC
);
   // input synchronizer stages and edge history
   logic trig_meta_ff;
   logic trig_sync_ff;
   logic pps_meta_ff;
   logic pps_sync_ff;
   logic pps_prev_ff;
   // ping gate counters, state and outputs
   logic [CNT_W-1:0] low_cnt_ff;
   logic [CNT_W-1:0] nxt_low_cnt;
   logic [CNT_W-1:0] pulse_cnt_ff;
   logic [CNT_W-1:0] nxt_pulse_cnt;
   pts_ping_t ping_st_ff;
   pts_ping_t nxt_ping_st;
   logic tx_start_ff;
   logic nxt_tx_start;
   logic sync_n_ff;
   logic nxt_sync_n;
   // time of day counters
   logic [SUB_W-1:0] ns_ff;
   logic [SUB_W-1:0] us_ff;
   logic [SUB_W-1:0] ms_ff;
   logic [SUB_W-1:0] nxt_ns;
   logic [SUB_W-1:0] nxt_us;
   logic [SUB_W-1:0] nxt_ms;
   logic [SEC_W-1:0] sec_ff;
   logic [SEC_W-1:0] nxt_sec;
   // one-cycle strobe on the synchronized second edge
   logic pps_rise;

   // wrap test shared by the counter chain
   function automatic logic at_wrap(input logic [SUB_W-1:0] v);
      at_wrap = (v == SUB_W'(TICK_WRAP - 1));
   endfunction : at_wrap

   // two-stage synchronizers; second stage feeds all logic
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         trig_meta_ff <= 1'b1;
         trig_sync_ff <= 1'b1;
         pps_meta_ff <= 1'b0;
         pps_sync_ff <= 1'b0;
         pps_prev_ff <= 1'b0;
      end else begin
         trig_meta_ff <= PING_TRIGGER_LINE;
         trig_sync_ff <= trig_meta_ff;
         pps_meta_ff <= PULSE_PER_SECOND_INPUT;
         pps_sync_ff <= pps_meta_ff;
         pps_prev_ff <= pps_sync_ff;
      end
   end

   // rising edge of the second pulse marks the boundary
   assign pps_rise = pps_sync_ff & ~pps_prev_ff;

   // ping gate: measure low time, fire once, wait for release high
   always_comb begin
      nxt_ping_st = ping_st_ff;
      nxt_low_cnt = low_cnt_ff;
      nxt_pulse_cnt = pulse_cnt_ff;
      nxt_tx_start = 1'b0;
      nxt_sync_n = sync_n_ff;
      if (trig_sync_ff) begin
         nxt_low_cnt = '0;
      end else if (low_cnt_ff < CNT_W'(TRIG_CYC)) begin
         nxt_low_cnt = low_cnt_ff + 1'b1;
      end
      case (ping_st_ff)
         PTS_ARMED: begin
            if (!trig_sync_ff && low_cnt_ff >= CNT_W'(TRIG_CYC) && TX_READY) begin
               nxt_ping_st = PTS_FIRE;
            end
         end
         PTS_FIRE: begin
            if (trig_sync_ff) begin
               nxt_ping_st = PTS_ARMED;
            end else begin
               nxt_tx_start = 1'b1;
               nxt_ping_st = PTS_HOLD;
               if (MASTER_MODE) begin
                  nxt_sync_n = 1'b0;
                  nxt_pulse_cnt = CNT_W'(PULSE_CYC);
               end
            end
         end
         PTS_HOLD: begin
            if (trig_sync_ff) begin
               nxt_ping_st = PTS_ARMED; // one ping per low interval
            end
         end
         default: nxt_ping_st = PTS_ARMED;
      endcase
      if (pulse_cnt_ff != '0) begin
         nxt_pulse_cnt = pulse_cnt_ff - 1'b1;
         if (pulse_cnt_ff == CNT_W'(1)) begin
            nxt_sync_n = 1'b1;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         ping_st_ff <= PTS_ARMED;
         low_cnt_ff <= '0;
         pulse_cnt_ff <= '0;
         tx_start_ff <= 1'b0;
         sync_n_ff <= 1'b1;
      end else begin
         ping_st_ff <= nxt_ping_st;
         low_cnt_ff <= nxt_low_cnt;
         pulse_cnt_ff <= nxt_pulse_cnt;
         tx_start_ff <= nxt_tx_start;
         sync_n_ff <= nxt_sync_n;
      end
   end

   // time counter chain with second pulse realignment and host load
   always_comb begin
      nxt_ns = ns_ff;
      nxt_us = us_ff;
      nxt_ms = ms_ff;
      nxt_sec = sec_ff;
      if (pps_rise && !HOST_TIME_MODE) begin
         nxt_ns = SUB_RESET;
         nxt_us = SUB_RESET;
         nxt_ms = SUB_RESET;
         if (ms_ff < SUB_W'(HALF_SECOND_MS)) begin
            nxt_sec = SEC_RESET;
         end else begin
            nxt_sec = sec_ff + 1'b1;
         end
      end else if (HOST_TIME_MODE && HOST_SET_VALID) begin
         // host step lands exactly, so convergence is one load
         nxt_ns = SUB_RESET;
         nxt_us = SUB_RESET;
         nxt_ms = HOST_SET_MS;
         nxt_sec = HOST_SET_SEC;
      end else begin
         // one ns counter step per clock covers the clock period
         if (ns_ff >= SUB_W'(TICK_WRAP - CLK_PERIOD_NS)) begin
            nxt_ns = ns_ff + SUB_W'(CLK_PERIOD_NS) - SUB_W'(TICK_WRAP);
            if (at_wrap(us_ff)) begin
               nxt_us = SUB_RESET;
               if (at_wrap(ms_ff)) begin
                  nxt_ms = SUB_RESET;
                  nxt_sec = sec_ff + 1'b1;
               end else begin
                  nxt_ms = ms_ff + 1'b1;
               end
            end else begin
               nxt_us = us_ff + 1'b1;
            end
         end else begin
            nxt_ns = ns_ff + SUB_W'(CLK_PERIOD_NS);
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         ns_ff <= SUB_RESET;
         us_ff <= SUB_RESET;
         ms_ff <= SUB_RESET;
         sec_ff <= SEC_RESET;
      end else begin
         ns_ff <= nxt_ns;
         us_ff <= nxt_us;
         ms_ff <= nxt_ms;
         sec_ff <= nxt_sec;
      end
   end

   // outputs straight from flip-flops
   assign TX_START = tx_start_ff;
   assign SYNC_OUT_N = sync_n_ff;
   assign TIME_NS = ns_ff;
   assign TIME_US = us_ff;
   assign TIME_MS = ms_ff;
   assign TIME_SEC = sec_ff;
endmodule : pts_ping_time_sync

// [tb/pts_assertions.sv]
// assertion checker for the ping and time synchronization block
`timescale 1ns/100ps
module pts_chk
   import pts_pkg::*;
#(parameter int TRIG_CYC = 10, parameter int PULSE_CYC = 20) (
   // all ports of the block
   input wire logic CORE_CLK, SYS_RST, PING_TRIGGER_LINE, PULSE_PER_SECOND_INPUT, MASTER_MODE,
   input wire logic HOST_TIME_MODE, HOST_SET_VALID, TX_READY, TX_START, SYNC_OUT_N,
   input wire logic [SEC_W-1:0] HOST_SET_SEC, TIME_SEC,
   input wire logic [SUB_W-1:0] HOST_SET_MS, TIME_NS, TIME_US, TIME_MS
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   logic [CNT_W-1:0] lo_ff;
   logic [SUB_W-1:0] ms_ff;
   logic [SEC_W-1:0] sec_ff;
   // sync low length and the time seen at each second edge
   always_ff @(posedge CORE_CLK) begin
      lo_ff <= SYNC_OUT_N ? '0 : lo_ff + 1'b1;
      if ($rose(PULSE_PER_SECOND_INPUT)) begin
         ms_ff <= TIME_MS;
         sec_ff <= TIME_SEC;
      end
   end
   start_one_a: assert property (TX_START |=> !TX_START) else $error("start too long");
   held_off_a: assert property (TX_START |-> !$past(PING_TRIGGER_LINE, 6)) else $error("start while held");
   sync_low_a: assert property (TX_START && MASTER_MODE |-> !SYNC_OUT_N) else $error("no sync");
   sync_cause_a: assert property ($fell(SYNC_OUT_N) |-> TX_START) else $error("stray sync");
   sync_width_a: assert property ($rose(SYNC_OUT_N) |-> lo_ff == PULSE_CYC) else $error("sync width");
   pps_clear_a: assert property ($rose(PULSE_PER_SECOND_INPUT) && !HOST_TIME_MODE |-> ##[2:5]
      TIME_NS == 0 && TIME_US == 0 && TIME_MS == 0) else $error("time not cleared");
   sec_step_a: assert property ($rose(PULSE_PER_SECOND_INPUT) && !HOST_TIME_MODE |-> ##[2:5]
      TIME_NS == 0 && TIME_SEC == (ms_ff < HALF_SECOND_MS ? '0 : sec_ff + 1'b1)) else $error("bad second");
   us_carry_a: assert property (HOST_TIME_MODE && !HOST_SET_VALID && TIME_NS == 10'h3e0
      && TIME_US != 10'h3e7 |=> TIME_NS == 0 && TIME_US == $past(TIME_US) + 1'b1) else $error("no carry");
endmodule : pts_chk
bind pts_ping_time_sync pts_chk #(.TRIG_CYC(TRIG_CYC), .PULSE_CYC(PULSE_CYC)) chk_u (.*);

// [tb/pts_far_side.sv]
// far-side instrument and time source
`timescale 1ns/100ps
module pts_far_side (
   // pins toward the block
   input wire logic clk,
   output logic trig,
   output logic pps
);
   initial begin
      trig = 1'b1;
      pps = 1'b0;
   end
   // trigger low for a number of cycles, held off otherwise
   task automatic ping(input int low_cyc);
      @(negedge clk) trig = 1'b0;
      repeat (low_cyc) @(negedge clk);
      trig = 1'b1;
   endtask : ping
   // one second pulse, equal halves, rising edge on the boundary
   // the once-per-second time message rides outside this pin model
   task automatic second(input int half);
      @(negedge clk) pps = 1'b1;
      repeat (half) @(negedge clk);
      pps = 1'b0;
      repeat (half) @(negedge clk);
   endtask : second
endmodule : pts_far_side

// [tb/test_pts_ping_time_sync.sv]
// self-checking bench for the ping and time synchronization block
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module test_pts_ping_time_sync
   import pts_pkg::*;
;
   localparam int TRIG = 10;
   localparam int PULSE = 20;
   logic clk = 1'b0, rst = 1'b1, master = 1'b1, host = 1'b0, hvalid = 1'b0, trig, pps, start, sync_n;
   logic [SEC_W-1:0] hsec = '0, t_sec;
   logic [SUB_W-1:0] hms = '0, t_ns, t_us, t_ms;
   int errors = 0, num_checks = 0, cyc = 0, starts = 0, lows = 0;
   always #4 clk = ~clk;
   pts_far_side far_u (.clk(clk), .trig(trig), .pps(pps));
   pts_ping_time_sync #(.TRIG_CYC(TRIG), .PULSE_CYC(PULSE)) dut_u (.CORE_CLK(clk), .SYS_RST(rst),
      .PING_TRIGGER_LINE(trig), .PULSE_PER_SECOND_INPUT(pps), .MASTER_MODE(master), .HOST_TIME_MODE(host),
      .HOST_SET_VALID(hvalid), .HOST_SET_SEC(hsec), .HOST_SET_MS(hms), .TX_READY(1'b1), .TX_START(start),
      .SYNC_OUT_N(sync_n), .TIME_NS(t_ns), .TIME_US(t_us), .TIME_MS(t_ms), .TIME_SEC(t_sec));
   task automatic summarize();
      if (errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize
   // counts starts and sync low cycles, cuts a hang short
   always @(posedge clk) begin
      starts += (start === 1'b1);
      lows += (sync_n === 1'b0);
      cyc++;
      if (cyc == 3000) begin
         errors++;
         summarize();
      end
   end
   // one trigger low interval, then count what followed
   task automatic ping_case(input int low_cyc, input logic mst, input int exp_starts);
      @(negedge clk);
      master = mst;
      starts = 0;
      lows = 0;
      far_u.ping(low_cyc);
      repeat (TRIG + PULSE + 10) @(negedge clk);
      `CHK("starts", exp_starts, starts)
      `CHK("sync low", (mst && exp_starts) ? PULSE : 0, lows)
   endtask : ping_case
   // host load, then a second pulse realigns the time
   task automatic pps_case(input logic [SUB_W-1:0] ms, input logic [SEC_W-1:0] exp_sec);
      @(negedge clk);
      host = 1'b1;
      hsec = 32'h0000_0005;
      hms = ms;
      hvalid = 1'b1;
      @(negedge clk);
      hvalid = 1'b0;
      repeat (130) @(negedge clk);
      `CHK("host ms", ms, t_ms)
      `CHK("host sec", 32'h0000_0005, t_sec)
      host = 1'b0;
      far_u.second(10);
      `CHK("ms", 10'h000, t_ms)
      `CHK("us", 10'h000, t_us)
      `CHK("ns", SUB_W'(CLK_PERIOD_NS * 17), t_ns)
      `CHK("sec", exp_sec, t_sec)
   endtask : pps_case
   // main sequence
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      ping_case(TRIG - 2, 1'b1, 0);
      ping_case(TRIG + 5, 1'b1, 1);
      ping_case(TRIG + 5, 1'b0, 1);
      pps_case(10'h1f4, 32'h0000_0006);
      pps_case(10'h1f3, 32'h0000_0000);
      summarize();
   end
endmodule : test_pts_ping_time_sync
